// file: src/tpi_pkg.sv
// tpi_pkg: register map, field positions and carrier types for the timer
// and pin interrupt logic; assumes a single 125 MHz clock domain.
package tpi_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] TIMER_FLAG_BITS_OFS   = 8'h38;
  localparam logic [7:0] TIMER_IRQ_ENABLES_OFS = 8'h39;
  localparam logic [7:0] EXT_CTRL_OFS          = 8'h3A;
  localparam logic [7:0] EXT_FLAG_OFS          = 8'h3B;
  localparam logic [7:0] IRQ_STATUS_OFS        = 8'h3C;
  localparam logic [7:0] IRQ_MASK_OFS          = 8'h3D;

  localparam logic [7:0] RESET_VALUE = 8'h00;

  // timer bit positions (flags and enables share the layout)
  localparam int CNT2_CMP_BIT  = 7;
  localparam int CNT2_OVF_BIT  = 6;
  localparam int CNT1_CAP_BIT  = 5;
  localparam int CNT1_CMPA_BIT = 4;
  localparam int CNT1_CMPB_BIT = 3;
  localparam int CNT1_OVF_BIT  = 2;
  localparam int CNT0_CMP_BIT  = 1;
  localparam int CNT0_OVF_BIT  = 0;

  // external control register fields
  localparam int PIN0_SENSE_LO_BIT = 0;
  localparam int PIN1_SENSE_LO_BIT = 2;
  localparam int PIN2_RISE_BIT     = 4;
  localparam int PIN0_EN_BIT       = 5;
  localparam int PIN1_EN_BIT       = 6;
  localparam int PIN2_EN_BIT       = 7;

  // external flag / irq status bit positions
  localparam int EXT0_BIT = 0;
  localparam int EXT1_BIT = 1;
  localparam int EXT2_BIT = 2;
  localparam int EXT_W    = 3;
  // irq status: bit 0 timer request, bit 1 external request
  localparam int ST_TIMER_BIT = 0;
  localparam int ST_EXT_BIT   = 1;
  localparam int ST_W         = 2;

  typedef enum logic [1:0] {
    SENSE_LOW   = 2'b00,
    SENSE_ANY   = 2'b01,
    SENSE_FALL  = 2'b10,
    SENSE_RISE  = 2'b11
  } tpi_sense_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } tpi_bus_req_type;

  // per-counter events from the timer units
  typedef struct packed {
    logic [7:0]  cnt2_value;
    logic [7:0]  cnt2_compare_value;
    logic        cnt2_ovf;
    logic        cnt2_bottom_turn;
    logic [15:0] cnt1_value;
    logic [15:0] cnt1_compare_value_a;
    logic [15:0] cnt1_compare_value_b;
    logic        cnt1_ovf;
    logic        cnt1_bottom_turn;
    logic        cnt1_capture;
    logic [7:0]  cnt0_value;
    logic [7:0]  cnt0_compare_value;
    logic        cnt0_ovf;
    logic        cnt0_bottom_turn;
    logic [2:0]  pwm_mode;
    logic        cnt_tick;
  } tpi_timer_ev_type;

endpackage

// file: src/tpi_pin_sense.sv
// tpi_pin_sense: one external pin trigger detector.
// assumes the pin level is already synchronous to core_clk_i.
module tpi_pin_sense (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rstn_i,
  // pin and mode
  input  wire logic                 pin_i,
  input  wire tpi_pkg::tpi_sense_type sense_i,
  // result
  output logic                      edge_o,
  output logic                      low_o
);

  logic prev;

  // sampled before edge detection, so pulses over one clock are caught
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      prev <= 1'b1;
    end else begin
      prev <= pin_i;
    end
  end

  always_comb begin
    unique case (sense_i)
      tpi_pkg::SENSE_LOW:  edge_o = 1'b0;
      tpi_pkg::SENSE_ANY:  edge_o = prev ^ pin_i;
      tpi_pkg::SENSE_FALL: edge_o = prev & ~pin_i;
      tpi_pkg::SENSE_RISE: edge_o = ~prev & pin_i;
    endcase
  end

  assign low_o = (sense_i == tpi_pkg::SENSE_LOW) & ~pin_i;

endmodule

// file: src/tpi_irq_logic.sv
// tpi_irq_logic: flags, enables and request gating for three counters and
// three external interrupt pins. assumes the core pulses vector_ack_i for
// one cycle with the source index when it enters a handler.
//
// Chosen here: the plain strobed port.
module tpi_irq_logic (
  // clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     rstn_i,
  // register port
  input  wire tpi_pkg::tpi_bus_req_type bus_i,
  output logic [7:0]                    rdata_o,
  // timer units
  input  wire tpi_pkg::tpi_timer_ev_type tmr_i,
  input  wire logic                     capture_input_pin_i,
  // external pins, read back from the pad (also when driven out)
  input  wire logic                     ext_irq_pin_0_i,
  input  wire logic                     ext_irq_pin_1_i,
  input  wire logic                     ext_irq_pin_2_i,
  // core
  input  wire logic                     global_irq_en_i,
  input  wire logic                     vector_ack_i,
  input  wire logic [3:0]               vector_src_i,
  output logic [7:0]                    timer_req_o,
  output logic [2:0]                    ext_req_o,
  output logic                          irq_o
);

  localparam logic [3:0] SRC_EXT0 = 4'h8;
  localparam logic [3:0] SRC_EXT1 = 4'h9;
  localparam logic [3:0] SRC_EXT2 = 4'hA;

  typedef enum logic [1:0] {
    CAP_IDLE = 2'b01,
    CAP_SEEN = 2'b10
  } tpi_cap_state_type;

  // registers
  logic [7:0]              timer_flag_bits;
  logic [7:0]              timer_irq_enables;
  logic [7:0]              ext_ctrl;
  logic [tpi_pkg::EXT_W-1:0] ext_flag;
  logic [tpi_pkg::ST_W-1:0]  irq_status;
  logic [tpi_pkg::ST_W-1:0]  irq_mask;
  // per-cycle set and clear terms, pin levels, enables and flag view
  logic [7:0]              timer_set;
  logic [7:0]              timer_clr;
  logic [tpi_pkg::EXT_W-1:0] ext_set;
  logic [tpi_pkg::EXT_W-1:0] ext_clr;
  logic [tpi_pkg::EXT_W-1:0] ext_level;
  logic [tpi_pkg::EXT_W-1:0] ext_en;
  logic [tpi_pkg::EXT_W-1:0] ext_flag_view;
  logic [tpi_pkg::ST_W-1:0]  st_set;
  logic [tpi_pkg::ST_W-1:0]  st_clr;
  // pin sense modes and results, edge history and capture state
  logic                    edge0;
  logic                    edge1;
  logic                    low0;
  logic                    low1;
  logic                    cap_prev;
  logic                    prev2;
  tpi_cap_state_type       cap_state;
  tpi_cap_state_type       next_cap_state;
  tpi_pkg::tpi_sense_type  sense0;
  tpi_pkg::tpi_sense_type  sense1;

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = bus_i.wr && (bus_i.addr == ofs);
  endfunction

  function automatic logic ovf_event(input logic pwm, input logic ovf,
                                     input logic turn);
    ovf_event = pwm ? turn : ovf;
  endfunction

  // a match only counts on a timer tick, not on every clock it is held
  function automatic logic cmp_event(input logic        tick,
                                     input logic [15:0] value,
                                     input logic [15:0] compare);
    cmp_event = tick && (value == compare);
  endfunction

  // one edge detector shared by the capture pin and pin 2
  function automatic logic edge_event(input logic rise, input logic prev,
                                      input logic now);
    edge_event = rise ? (now & ~prev) : (prev & ~now);
  endfunction

  assign sense0 = tpi_pkg::tpi_sense_type'(
    ext_ctrl[tpi_pkg::PIN0_SENSE_LO_BIT +: 2]);
  assign sense1 = tpi_pkg::tpi_sense_type'(
    ext_ctrl[tpi_pkg::PIN1_SENSE_LO_BIT +: 2]);
  assign ext_en = {ext_ctrl[tpi_pkg::PIN2_EN_BIT],
                   ext_ctrl[tpi_pkg::PIN1_EN_BIT],
                   ext_ctrl[tpi_pkg::PIN0_EN_BIT]};

  // pad inputs are read back, so a driven pin still triggers
  tpi_pin_sense u_sense0 (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .pin_i      (ext_irq_pin_0_i),
    .sense_i    (sense0),
    .edge_o     (edge0),
    .low_o      (low0)
  );

  tpi_pin_sense u_sense1 (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .pin_i      (ext_irq_pin_1_i),
    .sense_i    (sense1),
    .edge_o     (edge1),
    .low_o      (low1)
  );

  // capture pin and pin 2 edge trackers; a rising capture pin edge triggers a capture
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cap_prev <= 1'b0;
      // pin 2 idles high: a low start would fake a rising edge
      prev2    <= 1'b1;
    end else begin
      cap_prev <= capture_input_pin_i;
      prev2    <= ext_irq_pin_2_i;
    end
  end

  // the flag follows the pin edge by two cycles: see it, then latch it
  always_comb begin
    unique case (cap_state)
      CAP_IDLE: next_cap_state = edge_event(1'b1, cap_prev,
                  capture_input_pin_i) ? CAP_SEEN : CAP_IDLE;
      CAP_SEEN: next_cap_state = CAP_IDLE;
      default:  next_cap_state = CAP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cap_state <= CAP_IDLE;
    end else begin
      cap_state <= next_cap_state;
    end
  end

  always_comb begin
    timer_set = '0;
    timer_set[tpi_pkg::CNT2_CMP_BIT] = cmp_event(tmr_i.cnt_tick,
      16'(tmr_i.cnt2_value), 16'(tmr_i.cnt2_compare_value));
    timer_set[tpi_pkg::CNT2_OVF_BIT] = ovf_event(tmr_i.pwm_mode[2],
      tmr_i.cnt2_ovf, tmr_i.cnt2_bottom_turn);
    // the unit's capture strobe marks the copy into the capture register
    timer_set[tpi_pkg::CNT1_CAP_BIT] = tmr_i.cnt1_capture ||
      (cap_state == CAP_SEEN);
    timer_set[tpi_pkg::CNT1_CMPA_BIT] = cmp_event(tmr_i.cnt_tick,
      tmr_i.cnt1_value, tmr_i.cnt1_compare_value_a);
    timer_set[tpi_pkg::CNT1_CMPB_BIT] = cmp_event(tmr_i.cnt_tick,
      tmr_i.cnt1_value, tmr_i.cnt1_compare_value_b);
    timer_set[tpi_pkg::CNT1_OVF_BIT] = ovf_event(tmr_i.pwm_mode[1],
      tmr_i.cnt1_ovf, tmr_i.cnt1_bottom_turn);
    timer_set[tpi_pkg::CNT0_CMP_BIT] = cmp_event(tmr_i.cnt_tick,
      16'(tmr_i.cnt0_value), 16'(tmr_i.cnt0_compare_value));
    timer_set[tpi_pkg::CNT0_OVF_BIT] = ovf_event(tmr_i.pwm_mode[0],
      tmr_i.cnt0_ovf, tmr_i.cnt0_bottom_turn);
  end

  always_comb begin
    timer_clr = '0;
    if (wr_hit(tpi_pkg::TIMER_FLAG_BITS_OFS)) begin
      timer_clr = bus_i.wdata;
    end
    // pin sources sit above the timer indices and clear in the pin path
    if (vector_ack_i && vector_src_i < SRC_EXT0) begin
      timer_clr[vector_src_i[2:0]] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      timer_flag_bits <= tpi_pkg::RESET_VALUE;
    end else begin
      timer_flag_bits <= (timer_flag_bits & ~timer_clr) | timer_set;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      timer_irq_enables <= tpi_pkg::RESET_VALUE;
    end else if (wr_hit(tpi_pkg::TIMER_IRQ_ENABLES_OFS)) begin
      timer_irq_enables <= bus_i.wdata;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ext_ctrl <= tpi_pkg::RESET_VALUE;
    end else if (wr_hit(tpi_pkg::EXT_CTRL_OFS)) begin
      ext_ctrl <= bus_i.wdata;
    end
  end

  // pin 2 has no level mode: its single bit picks rise or fall
  always_comb begin
    ext_set = '0;
    ext_set[tpi_pkg::EXT0_BIT] = edge0;
    ext_set[tpi_pkg::EXT1_BIT] = edge1;
    ext_set[tpi_pkg::EXT2_BIT] = edge_event(
      ext_ctrl[tpi_pkg::PIN2_RISE_BIT], prev2, ext_irq_pin_2_i);
    ext_clr = '0;
    if (wr_hit(tpi_pkg::EXT_FLAG_OFS)) begin
      ext_clr = bus_i.wdata[tpi_pkg::EXT_W-1:0];
    end
    if (vector_ack_i) begin
      if (vector_src_i == SRC_EXT0) ext_clr[tpi_pkg::EXT0_BIT] = 1'b1;
      if (vector_src_i == SRC_EXT1) ext_clr[tpi_pkg::EXT1_BIT] = 1'b1;
      if (vector_src_i == SRC_EXT2) ext_clr[tpi_pkg::EXT2_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ext_flag <= '0;
    end else begin
      ext_flag <= (ext_flag & ~ext_clr) | ext_set;
    end
  end

  // level mode has no memory: the flag reads clear, the low pin requests
  assign ext_level = {1'b0, low1, low0};
  assign ext_flag_view = ext_flag &
    ~{1'b0, sense1 == tpi_pkg::SENSE_LOW, sense0 == tpi_pkg::SENSE_LOW};

  assign timer_req_o = timer_flag_bits & timer_irq_enables &
    {8{global_irq_en_i}};
  assign ext_req_o = (ext_flag_view | ext_level) & ext_en &
    {tpi_pkg::EXT_W{global_irq_en_i}};

  // summary status for the interrupt line, independent of the global bit
  assign st_set = {|(ext_flag_view | ext_level),
                   |(timer_flag_bits & timer_irq_enables)};

  // write-one clear of the summary bits; a cause that persists sets again
  always_comb begin
    st_clr = '0;
    if (wr_hit(tpi_pkg::IRQ_STATUS_OFS)) begin
      st_clr = bus_i.wdata[tpi_pkg::ST_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      irq_mask <= '0;
    end else if (wr_hit(tpi_pkg::IRQ_MASK_OFS)) begin
      irq_mask <= bus_i.wdata[tpi_pkg::ST_W-1:0];
    end
  end

  assign irq_o = |(irq_status & irq_mask);

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else if (bus_i.rd) begin
      unique case (bus_i.addr)
        tpi_pkg::TIMER_FLAG_BITS_OFS:   rdata_o <= timer_flag_bits;
        tpi_pkg::TIMER_IRQ_ENABLES_OFS: rdata_o <= timer_irq_enables;
        tpi_pkg::EXT_CTRL_OFS:          rdata_o <= ext_ctrl;
        tpi_pkg::EXT_FLAG_OFS:  rdata_o <= {5'h00, ext_flag_view};
        tpi_pkg::IRQ_STATUS_OFS:        rdata_o <= {6'h00, irq_status};
        tpi_pkg::IRQ_MASK_OFS:          rdata_o <= {6'h00, irq_mask};
        default:                        rdata_o <= '0;
      endcase
    end else begin
      // data stand for one cycle only, then the port reads zero
      rdata_o <= '0;
    end
  end

endmodule

// file: bench/tpi_core_model.sv
// tpi_core_model: core side that vectors to pending sources.
// assumes requests are combinational from the dut's registers.
module tpi_core_model (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  // control and requests
  input  wire logic       serve_i,
  input  wire logic [7:0] timer_req_i,
  input  wire logic [2:0] ext_req_i,
  // vectoring
  output logic            vector_ack_o,
  output logic [3:0]      vector_src_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        ack_q = 1'b0;
  logic [3:0]  src_q = 4'h0;
  logic [10:0] pend;
  assign pend = {ext_req_i, timer_req_i};
  assign vector_ack_o = ack_q;
  assign vector_src_o = src_q;
  // idle a cycle after each entry so a flag being cleared is not taken twice
  always @(posedge core_clk_i) begin
    logic       take;
    logic [3:0] pick;
    take = rstn_i && serve_i && !ack_q && |pend;
    pick = src_q;
    // lowest pending index wins, as in a fixed-priority vector table
    for (int i = 10; i >= 0; i--) begin
      if (pend[i]) begin
        pick = 4'(i);
      end
    end
    ack_q <= take;
    src_q <= take ? pick : src_q;
  end
endmodule

// file: bench/tpi_irq_logic_props.sv
// tpi_irq_logic_props: port assertions for tpi_irq_logic.
// assumes one clock and the synchronous active-low reset of the dut.
module tpi_irq_logic_props (
  // clock and reset
  input wire logic                      core_clk_i,
  input wire logic                      rstn_i,
  // register port
  input wire tpi_pkg::tpi_bus_req_type  bus_i,
  input wire logic [7:0]                rdata_o,
  // events and core
  input wire tpi_pkg::tpi_timer_ev_type tmr_i,
  input wire logic                      global_irq_en_i,
  input wire logic                      vector_ack_i,
  input wire logic [3:0]                vector_src_i,
  input wire logic [7:0]                timer_req_o,
  input wire logic [2:0]                ext_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // shadow of enable bit 0, rebuilt from bus writes alone
  logic en0_seen = 1'b0;
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      en0_seen <= 1'b0;
    end else if (bus_i.wr && bus_i.addr == 8'h39) begin
      en0_seen <= bus_i.wdata[0];
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_set_with_clear;
    bus_i.wr && bus_i.addr == 8'h38 && bus_i.wdata[0]
      && tmr_i.cnt0_ovf && !tmr_i.pwm_mode[0];
  endsequence
  sequence s_clear_bit0;
    bus_i.wr && bus_i.addr == 8'h38 && bus_i.wdata[0]
      && !tmr_i.cnt0_ovf && !tmr_i.cnt0_bottom_turn;
  endsequence
  a_timer_req_gated: assert property (
    |timer_req_o |-> global_irq_en_i)
    else $error("timer request without global enable");
  a_ext_req_gated: assert property (
    |ext_req_o |-> global_irq_en_i)
    else $error("pin request without global enable");
  a_rdata_idle_zero: assert property (
    !$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_reads_zero: assert property (
    bus_i.rd && bus_i.addr == 8'h40 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_vector_clears_flag: assert property (
    vector_ack_i && vector_src_i == 4'h0 && !tmr_i.cnt0_ovf
      && !tmr_i.cnt0_bottom_turn |=> !timer_req_o[0])
    else $error("vectoring left flag set");
  a_write_one_clears: assert property (
    s_clear_bit0 |=> !timer_req_o[0])
    else $error("write one left flag set");
  a_set_beats_clear: assert property (
    s_set_with_clear ##1 (global_irq_en_i && en0_seen) |-> timer_req_o[0])
    else $error("set lost against clear");
  a_ovf_req_cause: assert property (
    $rose(timer_req_o[0]) |-> $rose(global_irq_en_i) || $past(bus_i.wr)
      || $past(tmr_i.cnt0_ovf && !tmr_i.pwm_mode[0])
      || $past(tmr_i.cnt0_bottom_turn && tmr_i.pwm_mode[0]))
    else $error("overflow request without cause");
endmodule

bind tpi_irq_logic tpi_irq_logic_props u_props (
  .core_clk_i, .rstn_i, .bus_i, .rdata_o, .tmr_i, .global_irq_en_i,
  .vector_ack_i, .vector_src_i, .timer_req_o, .ext_req_o);

// file: bench/tb_tpi_irq_logic.sv
// tb_tpi_irq_logic: register-level tests of the interrupt logic.
// assumes the core model and the bound checker are compiled first.
module tb_tpi_irq_logic;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] LO_REQ = 4'h7, LO_FLAG = 4'h6, HI_FLAG = 4'hE;
  logic                      core_clk_i = 1'b0;
  logic                      rstn_i = 1'b0;
  tpi_pkg::tpi_bus_req_type  bus = '0;
  tpi_pkg::tpi_timer_ev_type tmr = '0;
  logic                      cap = 1'b0;
  logic [2:0]                pins = 3'h7;
  logic                      glb = 1'b0;
  logic                      serve = 1'b0;
  logic                      ack;
  logic [3:0]                src;
  logic [7:0]                rdata;
  logic [7:0]                treq;
  logic [2:0]                ereq;
  logic                      irq;
  int                        num_errors = 0;
  int                        checks = 0;
  always #4 core_clk_i = ~core_clk_i;
  tpi_irq_logic dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .bus_i(bus),
    .rdata_o(rdata), .tmr_i(tmr), .capture_input_pin_i(cap),
    .ext_irq_pin_0_i(pins[0]), .ext_irq_pin_1_i(pins[1]),
    .ext_irq_pin_2_i(pins[2]), .global_irq_en_i(glb), .vector_ack_i(ack),
    .vector_src_i(src), .timer_req_o(treq), .ext_req_o(ereq), .irq_o(irq));
  tpi_core_model core (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .serve_i(serve), .timer_req_i(treq), .ext_req_i(ereq),
    .vector_ack_o(ack), .vector_src_o(src));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic drv(input logic [2:0] k);
    tmr.cnt_tick <= k[0];
    tmr.cnt0_ovf <= k[1];
    tmr.cnt1_ovf <= k[1];
    tmr.cnt2_ovf <= k[1];
    tmr.cnt0_bottom_turn <= k[2];
    tmr.cnt1_bottom_turn <= k[2];
    tmr.cnt2_bottom_turn <= k[2];
  endtask
  // optional event pulse rides on the write edge to race set against clear
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [2:0] k = 3'h0);
    @(posedge core_clk_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    drv(k);
    @(posedge core_clk_i);
    bus.wr <= 1'b0;
    drv(3'h0);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge core_clk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge core_clk_i);
    bus.rd <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask
  task automatic pulse(input logic [2:0] k);
    @(posedge core_clk_i);
    drv(k);
    @(posedge core_clk_i);
    drv(3'h0);
  endtask
  initial begin
    tmr.cnt2_value = 8'h01;
    tmr.cnt1_value = 16'h0001;
    tmr.cnt0_value = 8'h01;
    repeat (12) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(8'h38, 8'h00, "timer flags");
    rd(8'h39, 8'h00, "timer enables");
    rd(8'h40, 8'h00, "unmapped");
    wr(8'h39, 8'hA5);
    rd(8'h39, 8'hA5, "timer enables");
    wr(8'h39, 8'hFF);
    tmr.cnt2_compare_value <= 8'h01;
    tmr.cnt1_compare_value_a <= 16'h0001;
    tmr.cnt1_compare_value_b <= 16'h0001;
    tmr.cnt0_compare_value <= 8'h01;
    pulse(3'h1);
    pulse(3'h2);
    @(posedge core_clk_i);
    cap <= 1'b1;
    // the pin edge takes two cycles to reach the flag
    @(posedge core_clk_i);
    rd(8'h38, 8'hFF, "timer flags");
    chk("timer requests", 8'h00, treq);
    @(posedge core_clk_i);
    glb <= 1'b1;
    wr(8'h39, 8'h0F);
    chk("timer requests", 8'h0F, treq);
    wr(8'h39, 8'hFF);
    wr(8'h38, 8'h0E);
    rd(8'h38, 8'hF1, "timer flags");
    wr(8'h38, 8'h01, 3'h2);
    rd(8'h38, 8'hF5, "set beats clear");
    wr(8'h38, 8'hFF);
    tmr.pwm_mode <= 3'h7;
    pulse(3'h2);
    rd(8'h38, 8'h00, "pwm overflow");
    pulse(3'h4);
    rd(8'h38, 8'h45, "pwm bottom");
    serve <= 1'b1;
    repeat (40) begin
      @(posedge core_clk_i);
      if (treq === 8'h00) break;
    end
    if (treq !== 8'h00) begin
      num_errors++;
      finish_test();
    end
    serve <= 1'b0;
    rd(8'h38, 8'h00, "vectored flags");
    @(posedge core_clk_i);
    tmr.cnt1_capture <= 1'b1;
    @(posedge core_clk_i);
    tmr.cnt1_capture <= 1'b0;
    rd(8'h38, 8'h20, "capture strobe");
    wr(8'h38, 8'h20);
    wr(8'h3A, 8'hEE);
    // pins driven as outputs still reach the sense logic via the pad
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk_i);
      pins <= s[0] ? (s[1] ? 3'h6 : 3'h4) : (s[1] ? 3'h2 : 3'h6);
    end
    rd(8'h3B, 8'h07, "pin flags");
    chk("pin requests", 8'h07, {5'h00, ereq});
    pins <= 3'h7;
    wr(8'h3B, 8'h07);
    rd(8'h3B, 8'h00, "pin flags");
    for (int c = 0; c < 4; c++) begin
      wr(8'h3A, 8'h20 | 8'(c));
      wr(8'h3B, 8'h07);
      pins[0] <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      #1;
      chk("pin0 low req", {7'h00, LO_REQ[c]}, {7'h00, ereq[0]});
      rd(8'h3B, {7'h00, LO_FLAG[c]}, "pin0 low flag");
      pins[0] <= 1'b1;
      rd(8'h3B, {7'h00, HI_FLAG[c]}, "pin0 high flag");
    end
    wr(8'h3D, 8'h00);
    chk("masked irq", 8'h00, {7'h00, irq});
    wr(8'h3D, 8'h02);
    chk("raised irq", 8'h01, {7'h00, irq});
    wr(8'h3B, 8'h07);
    wr(8'h3C, 8'h03);
    rd(8'h3C, 8'h00, "irq status");
    chk("cleared irq", 8'h00, {7'h00, irq});
    wr(8'h3A, 8'h90);
    pins[2] <= 1'b0;
    rd(8'h3B, 8'h00, "pin2 fall ignored");
    pins[2] <= 1'b1;
    rd(8'h3B, 8'h04, "pin2 rise flag");
    chk("pin2 irq", 8'h01, {7'h00, irq});
    serve <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    serve <= 1'b0;
    rd(8'h3B, 8'h00, "vectored pin flag");
    wr(8'h3A, 8'h40);
    pins[1] <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk("pin1 low req", 8'h02, {5'h00, ereq});
    pins[1] <= 1'b1;
    finish_test();
  end
endmodule
